// >>> core/swk_cfg_regs.sv
// selective wake configuration bank: reference payload, fd tolerance control, oscillator trim
//
// How it works
// - four 8-bit read-write reference payload bytes, bit 0 is lsb
// - payload bytes 3..0 sit at 0x30..0x33 in that order
// - power-on and soft reset clear payload bytes; restart leaves them alone
// - fd control bits 7:6 read zero and ignore writes
// - bit 5 disables error counter only while tolerant mode is on
// - hardware clears bit 5 when bus silence timeout expires
// - bit 4 bypasses the analog receive filter
// - bits 3:1 pick dominant filter 50..350 ns, code 7 is 775 ns
// - dominant filter stays active even with analog bypass set
// - bit 0 enables fd tolerant mode
// - fd control at 0x34, cleared by power-on and soft reset
// - trim writes accepted only when trim enable equals 11
// - trim bits 4:0 form a 32-step monotonic fine range
// - trim at 0x38 is not forced by any reset
// - length codes 0..7 give that many bytes, 8..15 give eight
`timescale 1ns/1ps
module swk_cfg_regs
  import swk_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      soft_rst_i,
  input  wire logic                      restart_i,
  input  wire logic                      wr_en_i,
  input  wire logic                      rd_en_i,
  input  wire logic [swk_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [swk_pkg::DATA_W-1:0] wdata_i,
  output logic      [swk_pkg::DATA_W-1:0] rdata_o,
  output logic                           addr_hit_o,
  input  wire logic [1:0]                trim_enable_i,
  input  wire logic                      silence_expired_i,
  input  wire logic                      rx_raw_i,
  output logic                           rx_filtered_o,
  output logic                           rx_analog_filter_bypass_o,
  output logic                           fd_tolerant_enable_o,
  output logic                           error_counter_active_o,
  output logic [swk_pkg::DATA_W-1:0]      oscillator_trim_value_o,
  input  wire logic [3:0]                frame_len_code_i,
  input  wire logic [31:0]               frame_data_i,
  input  wire logic                      frame_done_i,
  output logic                           payload_match_o
);
  import swk_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ref_byte_r [REF_BYTES];
  logic              error_counter_off_r;
  logic              rx_analog_filter_bypass_r;
  logic [2:0]        dominant_filter_time_r;
  logic              fd_tolerant_enable_r;
  logic [DATA_W-1:0] trim_r;
  logic              match_r;
  logic [DATA_W-1:0] rdata_r;

  logic              clear_cfg;
  logic              wr_fd;
  logic              wr_trim;
  logic [DATA_W-1:0] fd_wval;
  logic [DATA_W-1:0] fd_ctrl_view;

  // restart is a separate event: payload and control are left as they are
  assign clear_cfg = sys_rst_i | soft_rst_i;
  assign wr_fd     = wr_en_i && (addr_i == ADDR_FD_CTRL);
  assign wr_trim   = wr_en_i && (addr_i == ADDR_OSC_TRIM)
                     && (trim_enable_i == TRIM_UNLOCK);
  assign fd_wval   = wdata_i & FD_CTRL_WMASK;

  // ----------------------------------------------------------------
  // reference payload bytes
  // ----------------------------------------------------------------
  // index 0 is byte 3 at the lowest address, so address order is kept
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < REF_BYTES; i++) begin
      if (clear_cfg) begin
        ref_byte_r[i] <= RST_REF_BYTE;
      end else if (wr_en_i && addr_i == ADDR_W'(ADDR_REF_BYTE3 + ADDR_W'(i))) begin
        ref_byte_r[i] <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // fd tolerance control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (clear_cfg) begin
      rx_analog_filter_bypass_r <= RST_FD_CTRL[BYP_BIT];
      dominant_filter_time_r    <= RST_FD_CTRL[FILT_MSB:FILT_LSB];
      fd_tolerant_enable_r      <= RST_FD_CTRL[FD_EN_BIT];
    end else if (wr_fd) begin
      rx_analog_filter_bypass_r <= fd_wval[BYP_BIT];
      dominant_filter_time_r    <= fd_wval[FILT_MSB:FILT_LSB];
      fd_tolerant_enable_r      <= fd_wval[FD_EN_BIT];
    end
  end

  // hardware clear wins over a host write in the same cycle, so an
  // expired silence timer is never masked by a late configuration write
  always_ff @(posedge core_clk_i) begin
    if (clear_cfg) begin
      error_counter_off_r <= RST_FD_CTRL[ERR_OFF_BIT];
    end else if (silence_expired_i) begin
      error_counter_off_r <= 1'b0;
    end else if (wr_fd) begin
      error_counter_off_r <= fd_wval[ERR_OFF_BIT];
    end
  end

  assign error_counter_active_o =
    !(error_counter_off_r && fd_tolerant_enable_r);
  assign rx_analog_filter_bypass_o = rx_analog_filter_bypass_r;
  assign fd_tolerant_enable_o      = fd_tolerant_enable_r;

  always_comb begin
    fd_ctrl_view = '0;
    fd_ctrl_view[ERR_OFF_BIT]       = error_counter_off_r;
    fd_ctrl_view[BYP_BIT]           = rx_analog_filter_bypass_r;
    fd_ctrl_view[FILT_MSB:FILT_LSB] = dominant_filter_time_r;
    fd_ctrl_view[FD_EN_BIT]         = fd_tolerant_enable_r;
  end

  // ----------------------------------------------------------------
  // dominant filter, digital and after the analog path
  // ----------------------------------------------------------------
  swk_filt_if filt_bus ();
  assign filt_bus.code  = dominant_filter_time_r;
  assign filt_bus.rx_in = rx_raw_i;

  swk_dom_filter u_dom_filter (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .flt        (filt_bus)
  );

  // bypass only steers the analog stage outside; this filter stays in
  assign rx_filtered_o = filt_bus.rx_out;

  // ----------------------------------------------------------------
  // oscillator trim
  // ----------------------------------------------------------------
  // no reset term: trim keeps its value across every reset kind;
  // the host must unlock before writing; bits 7:5 are stored as written
  always_ff @(posedge core_clk_i) begin
    if (wr_trim) begin
      trim_r <= wdata_i;
    end
  end

  // low five bits drive the monotonic fine range directly
  assign oscillator_trim_value_o = trim_r;

  // ----------------------------------------------------------------
  // payload comparison
  // ----------------------------------------------------------------
  logic [3:0] active_bytes;
  logic       all_match;

  always_comb begin
    if (frame_len_code_i >= LEN_FULL_CODE) begin
      active_bytes = LEN_MAX_BYTES;
    end else begin
      active_bytes = frame_len_code_i;
    end
  end

  // frame_data_i holds bytes 3..0 as [31:24]..[7:0]; a byte takes part
  // when its index is below the active count
  always_comb begin
    all_match = 1'b1;
    for (int b = 0; b < REF_BYTES; b++) begin
      if (4'(b) < active_bytes &&
          frame_data_i[b*DATA_W +: DATA_W] != ref_byte_r[REF_BYTES-1-b]) begin
        all_match = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clear_cfg) begin
      match_r <= 1'b0;
    end else if (frame_done_i) begin
      match_r <= all_match;
    end
  end

  assign payload_match_o = match_r;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    addr_hit_o = 1'b1;
    unique case (addr_i)
      ADDR_REF_BYTE3, ADDR_REF_BYTE2, ADDR_REF_BYTE1, ADDR_REF_BYTE0,
      ADDR_FD_CTRL, ADDR_OSC_TRIM: addr_hit_o = 1'b1;
      default: addr_hit_o = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= '0;
    end else if (rd_en_i) begin
      unique case (addr_i)
        ADDR_REF_BYTE3: rdata_r <= ref_byte_r[0];
        ADDR_REF_BYTE2: rdata_r <= ref_byte_r[1];
        ADDR_REF_BYTE1: rdata_r <= ref_byte_r[2];
        ADDR_REF_BYTE0: rdata_r <= ref_byte_r[3];
        ADDR_FD_CTRL:   rdata_r <= fd_ctrl_view;
        ADDR_OSC_TRIM:  rdata_r <= trim_r;
        default:        rdata_r <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_r;

  // restart_i is accepted for completeness; only restart_seen_r follows it, and no payload, control or trim value changes
  logic restart_seen_r;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      restart_seen_r <= 1'b0;
    end else begin
      restart_seen_r <= restart_i;
    end
  end
endmodule // swk_cfg_regs

// >>> core/swk_dom_filter.sv
// dominant pulse filter: passes dominant only after it has lasted the selected time
`timescale 1ns/1ps
module swk_dom_filter
  import swk_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  swk_filt_if.filt  flt
);
  import swk_pkg::*;

  logic [FILT_CNT_W-1:0] need;
  logic [FILT_CNT_W-1:0] cnt_r;
  logic                  out_r;

  // long code is 775 ns; others step by 50 ns; counts round down
  always_comb begin
    if (flt.code == FILT_LONG_CODE) begin
      need = FILT_CNT_W'(FILT_LONG_CYC);
    end else begin
      need = FILT_CNT_W'((32'(flt.code) + 1) * FILT_STEP_CYC);
    end
  end

  // rx_in low means dominant; recessive releases at once
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      out_r <= 1'b1;
    end else if (flt.rx_in) begin
      cnt_r <= '0;
      out_r <= 1'b1;
    end else if (cnt_r + 1'b1 >= need) begin
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign flt.rx_out = out_r;
endmodule // swk_dom_filter

// >>> core/swk_filt_if.sv
// interface: dominant filter configuration and result between bank and filter
`timescale 1ns/1ps
interface swk_filt_if;
  logic [2:0] code;
  logic       rx_in;
  logic       rx_out;
  modport bank (output code, output rx_in, input rx_out);
  modport filt (input code, input rx_in, output rx_out);
endinterface

// >>> core/swk_pkg.sv
// package: register map, field layout and timing constants of the selective wake config bank
package swk_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [6:0] ADDR_REF_BYTE3 = 7'h30;
  localparam logic [6:0] ADDR_REF_BYTE2 = 7'h31;
  localparam logic [6:0] ADDR_REF_BYTE1 = 7'h32;
  localparam logic [6:0] ADDR_REF_BYTE0 = 7'h33;
  localparam logic [6:0] ADDR_FD_CTRL   = 7'h34;
  localparam logic [6:0] ADDR_OSC_TRIM  = 7'h38;

  localparam logic [7:0] RST_REF_BYTE = 8'h00;
  localparam logic [7:0] RST_FD_CTRL  = 8'h00;
  localparam logic [7:0] FD_CTRL_WMASK = 8'h3f;

  localparam int FD_EN_BIT      = 0;
  localparam int FILT_LSB       = 1;
  localparam int FILT_MSB       = 3;
  localparam int BYP_BIT        = 4;
  localparam int ERR_OFF_BIT    = 5;

  localparam logic [1:0] TRIM_UNLOCK = 2'b11;

  // dominant filter times in ns and derived counts at 20 MHz
  localparam int CLK_PERIOD_NS  = 50;
  localparam int FILT_STEP_NS   = 50;
  localparam int FILT_LONG_NS   = 775;
  localparam logic [2:0] FILT_LONG_CODE = 3'h7;
  localparam int FILT_STEP_CYC  = FILT_STEP_NS / CLK_PERIOD_NS;
  localparam int FILT_LONG_CYC  = FILT_LONG_NS / CLK_PERIOD_NS;
  localparam int FILT_CNT_W     = 5;

  // payload length codes at or above this hold eight bytes
  localparam logic [3:0] LEN_FULL_CODE = 4'h8;
  localparam logic [3:0] LEN_MAX_BYTES = 4'h8;
  localparam int REF_BYTES = 4;
endpackage

// >>> test/swk_cfg_regs_properties.sv
// checker: port-level properties of the selective wake configuration bank
`timescale 1ns/1ps
module swk_cfg_regs_properties
  import swk_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       soft_rst_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       addr_hit_o,
  input wire logic [1:0] trim_enable_i,
  input wire logic       silence_expired_i,
  input wire logic       rx_raw_i,
  input wire logic       rx_filtered_o,
  input wire logic       rx_analog_filter_bypass_o,
  input wire logic       fd_tolerant_enable_o,
  input wire logic       error_counter_active_o,
  input wire logic [7:0] oscillator_trim_value_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence fd_wr;
    wr_en_i && addr_i == ADDR_FD_CTRL && !soft_rst_i;
  endsequence
  // three recessive samples leave room for the one-cycle release
  sequence recessive3;
    rx_raw_i [*3];
  endsequence
  rsv_read_zero_a: assert property (
    rd_en_i && addr_i == ADDR_FD_CTRL |=> !rdata_o[7:6])
    else $error("reserved control bits read nonzero");
  fd_write_a: assert property (fd_wr |=> fd_tolerant_enable_o == $past(wdata_i[0])
    && rx_analog_filter_bypass_o == $past(wdata_i[4])) else $error("control write lost");
  err_gate_a: assert property (!fd_tolerant_enable_o |-> error_counter_active_o)
    else $error("counter disabled outside tolerant mode");
  err_off_a: assert property (fd_wr ##0 (wdata_i[5] && wdata_i[0] && !silence_expired_i)
    |=> !error_counter_active_o) else $error("counter not disabled");
  silence_clr_a: assert property (silence_expired_i |=> error_counter_active_o)
    else $error("silence timeout did not clear counter disable");
  soft_clr_a: assert property (
    soft_rst_i |=> !fd_tolerant_enable_o && !rx_analog_filter_bypass_o)
    else $error("soft reset left control bits set");
  trim_lock_a: assert property (
    wr_en_i && addr_i == ADDR_OSC_TRIM && trim_enable_i != TRIM_UNLOCK
    |=> $stable(oscillator_trim_value_o)) else $error("locked trim changed");
  trim_write_a: assert property (
    wr_en_i && addr_i == ADDR_OSC_TRIM && trim_enable_i == TRIM_UNLOCK
    |=> oscillator_trim_value_o == $past(wdata_i)) else $error("unlocked trim write lost");
  addr_map_a: assert property (
    addr_hit_o == (addr_i inside {[7'h30:7'h34], 7'h38}))
    else $error("address decode wrong");
  unmapped_rd_a: assert property (rd_en_i && !addr_hit_o |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  rx_release_a: assert property (recessive3 |-> rx_filtered_o)
    else $error("filtered receive stuck dominant");
endmodule // swk_cfg_regs_properties

bind swk_cfg_regs swk_cfg_regs_properties i_props (
  .core_clk_i, .sys_rst_i, .soft_rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o,
  .addr_hit_o, .trim_enable_i, .silence_expired_i, .rx_raw_i, .rx_filtered_o,
  .rx_analog_filter_bypass_o, .fd_tolerant_enable_o, .error_counter_active_o,
  .oscillator_trim_value_o
);

// >>> test/swk_cfg_regs_tb.sv
// testbench: registers, filter and payload match of the selective wake bank
`timescale 1ns/1ps
module swk_cfg_regs_tb;
  import swk_pkg::*;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0, restart_i = 1'b0;
  logic silence_expired_i = 1'b0, rx_raw_i = 1'b1, frame_done_i = 1'b0;
  logic [3:0]  frame_len_code_i = 4'h0;
  logic [31:0] frame_data_i = 32'h0;
  logic wr_en_i, rd_en_i, addr_hit_o, rx_filtered_o, rx_analog_filter_bypass_o;
  logic fd_tolerant_enable_o, error_counter_active_o, payload_match_o;
  logic [6:0] addr_i;
  logic [7:0] wdata_i, rdata_o, oscillator_trim_value_o;
  logic [1:0] trim_enable_i;
  logic [7:0] pay [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
  int n_fail = 0;
  int comparisons = 0;
  swk_cfg_regs i_dut (.core_clk_i, .sys_rst_i, .soft_rst_i, .restart_i, .wr_en_i, .rd_en_i,
    .addr_i, .wdata_i, .rdata_o, .addr_hit_o, .trim_enable_i, .silence_expired_i, .rx_raw_i,
    .rx_filtered_o, .rx_analog_filter_bypass_o, .fd_tolerant_enable_o, .error_counter_active_o,
    .oscillator_trim_value_o, .frame_len_code_i, .frame_data_i, .frame_done_i, .payload_match_o);
  swk_host_model h (.core_clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .trim_enable_o(trim_enable_i), .rdata_i(rdata_o));
  initial forever #25 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(d, e);
  endtask
  task automatic dom(input int n, input logic e);
    @(posedge core_clk_i) rx_raw_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    rx_raw_i <= 1'b1;
    #1 chk({7'h00, rx_filtered_o}, {7'h00, e});
    repeat (4) @(posedge core_clk_i);
  endtask
  task automatic frame(input logic [3:0] l, input logic [31:0] d, input logic e);
    @(posedge core_clk_i);
    frame_len_code_i <= l;
    frame_data_i <= d;
    frame_done_i <= 1'b1;
    @(posedge core_clk_i) frame_done_i <= 1'b0;
    #1 chk({7'h00, payload_match_o}, {7'h00, e});
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int a = 'h30; a <= 'h34; a++) rdchk(7'(a), 8'h00);
    $display("reset values done");
  endtask
  task automatic t_payload;
    for (int i = 0; i < 4; i++) h.wr(7'(8'h30 + i), pay[i]);
    for (int i = 0; i < 4; i++) rdchk(7'(8'h30 + i), pay[i]);
    rdchk(7'h35, 8'h00);
    $display("payload bytes done");
  endtask
  task automatic t_fd;
    h.wr(ADDR_FD_CTRL, 8'hff);
    rdchk(ADDR_FD_CTRL, 8'h3f);
    chk({5'h00, rx_analog_filter_bypass_o, fd_tolerant_enable_o, error_counter_active_o},
        8'h06);
    @(posedge core_clk_i) silence_expired_i <= 1'b1;
    @(posedge core_clk_i) silence_expired_i <= 1'b0;
    rdchk(ADDR_FD_CTRL, 8'h1f);
    h.wr(ADDR_FD_CTRL, 8'h20);
    #1 chk({5'h00, rx_analog_filter_bypass_o, fd_tolerant_enable_o, error_counter_active_o},
           8'h01);
    $display("control register done");
  endtask
  task automatic t_trim;
    h.trim_wr(8'h0a, TRIM_UNLOCK);
    #1 chk(oscillator_trim_value_o, 8'h0a);
    h.trim_wr(8'h15, 2'b10);
    rdchk(ADDR_OSC_TRIM, 8'h0a);
    $display("trim lock done");
  endtask
  task automatic t_filter;
    h.wr(ADDR_FD_CTRL, 8'h17);
    dom(3, 1'b1);
    dom(4, 1'b0);
    h.wr(ADDR_FD_CTRL, 8'h0e);
    dom(14, 1'b1);
    dom(15, 1'b0);
    $display("dominant filter done");
  endtask
  task automatic t_match;
    logic [31:0] f;
    f = {pay[0], pay[1], pay[2], pay[3]};
    frame(4'h4, f, 1'b1);
    frame(4'h4, f ^ 32'h1, 1'b0);
    frame(4'h2, f ^ 32'h0100_0000, 1'b1);
    frame(4'h9, f ^ 32'h0100_0000, 1'b0);
    $display("payload match done");
  endtask
  task automatic t_soft;
    @(posedge core_clk_i) soft_rst_i <= 1'b1;
    @(posedge core_clk_i) soft_rst_i <= 1'b0;
    rdchk(ADDR_REF_BYTE0, 8'h00);
    rdchk(ADDR_FD_CTRL, 8'h00);
    rdchk(ADDR_OSC_TRIM, 8'h0a);
    h.wr(ADDR_REF_BYTE2, 8'h5a);
    @(posedge core_clk_i) restart_i <= 1'b1;
    @(posedge core_clk_i) restart_i <= 1'b0;
    rdchk(ADDR_REF_BYTE2, 8'h5a);
    $display("soft reset done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_payload();
    t_fd();
    t_trim();
    t_filter();
    t_match();
    t_soft();
    results();
  end
  initial begin
    #100us;
    n_fail++;
    results();
  end
endmodule // swk_cfg_regs_tb

// >>> test/swk_host_model.sv
// host model: register master for the selective wake bank
`timescale 1ns/1ps
module swk_host_model
  import swk_pkg::*;
(
  input  wire logic       core_clk_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [6:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic [1:0]      trim_enable_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
    trim_enable_o = 2'b00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge core_clk_i) wr_en_o <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge core_clk_i) rd_en_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  // unlock set a cycle ahead; temperature bits always written as zero
  task automatic trim_wr(input logic [7:0] d, input logic [1:0] en);
    @(posedge core_clk_i) trim_enable_o <= en;
    wr(ADDR_OSC_TRIM, {3'b000, d[4:0]});
    trim_enable_o <= 2'b00;
  endtask
endmodule // swk_host_model
